// *** include/pll_cfg_regs.svh ***
// Register offsets, field positions and reset values of the PLL clock config word.
// Assumes inclusion by the design modules only.
`ifndef PLL_CFG_REGS_SVH
`define PLL_CFG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PRIMARY_CTRL_OFFSET  8'h00
`define PLL_CLK_CFG_OFFSET   8'h02

// ----------------------------------------------------------------
// Field positions in pll_clock_config and, at bit 24, the primary control register
// ----------------------------------------------------------------
`define DIV_RESET_BIT        22
`define IN_DIV_HI            21
`define IN_DIV_LO            20
`define DBL_ENABLE_BIT       19
`define PLL_ENABLE_BIT       18
`define PLL_REF_DIS_BIT      17
`define DBL_EDGE_BIT         16
`define FB_DIV_HI            15
`define FB_DIV_LO            8
`define MANUAL_CP_BIT        6
`define CP_CODE_HI           5
`define CP_CODE_LO           3
`define LOCK_DET_EN_BIT      2
`define LOCK_WIN_HI          1
`define LOCK_WIN_LO          0
`define LOCK_STATUS_BIT      24
`define VCO_CAL_BIT          24

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PLL_CLK_CFG_RESET    32'h0000_1900
`define FB_DIV_RESET         8'h19
`define LOCK_WIN_BASE        11'h080

`endif

// *** include/pll_cfg_pkg.sv ***
// Types shared by the PLL reference/config control block.
// Assumes nothing beyond a SystemVerilog compiler.
package pll_cfg_pkg;

  // ----------------------------------------------------------------
  // Lock detector states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LOCK_OFF   = 2'b00,
    LOCK_COUNT = 2'b01,
    LOCK_HELD  = 2'b10
  } lock_state_t;

endpackage : pll_cfg_pkg

// *** src/pll_ref_divider.sv ***
// Reference input divider: emits one-cycle enables at ref rate / 1,2,4,8.
// Assumes ref_tick is a one-cycle enable marking each reference cycle.
`timescale 1ns/1ps
`include "pll_cfg_regs.svh"

module pll_ref_divider #(
  parameter int CNT_W = 3                     // Counter width, covers divide by 8
) (
  input  wire logic       clock,              // System clock
  input  wire logic       rst_n,              // Synchronous reset, active low
  input  wire logic       div_reset,          // Holds divider in reset
  input  wire logic [1:0] div_sel,            // Ratio select 1,2,4,8
  input  wire logic       ref_tick,           // Reference cycle enable
  output logic            div_tick            // Divided reference enable
);

  logic [CNT_W-1:0] cnt_ff;                   // Phase counter
  logic [CNT_W-1:0] nxt_cnt;
  logic             tick_ff;                  // Registered output tick
  logic             nxt_tick;
  logic [CNT_W-1:0] top;                      // Terminal count for the ratio

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    top      = CNT_W'((1 << div_sel) - 1);    // RULE2
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (div_reset) begin                      // RULE1
      nxt_cnt = '0;
    end else if (ref_tick) begin
      if (cnt_ff >= top) begin                // Wrap, emit one divided tick
        nxt_cnt  = '0;
        nxt_tick = 1'b1;                      // RULE2
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign div_tick = tick_ff;

  // Divider held in reset never ticks
  property p_div_quiet;
    @(posedge clock) disable iff (!rst_n)
      div_reset |=> !div_tick;
  endproperty
  a_div_quiet: assert property (p_div_quiet) else $error("divider ticked in reset"); // RULE1

endmodule : pll_ref_divider

// *** src/pll_refclk_config_control.sv ***
// PLL reference clock configuration control word and lock detector.
// Assumes a host programming port with synchronous write/read strobes
// and phase-error and calibration status from the analog PLL.
//
// Notes on behaviour
// RULE1 - Divider reset bit 22 holds input divider reset
// RULE2 - Bits 21:20 divide reference by 1,2,4,8
// RULE3 - Software sets doubler enable bit 19
// RULE4 - Bit 16 and bit 19 both needed to double
// RULE5 - Bit 18 selects PLL output as system clock
// RULE6 - Software runs VCO calibration after PLL enable
// RULE7 - Software keeps reference disable bit 17 zero
// RULE8 - Bits 15:8 hold N, multiplication is 2N
// RULE9 - Software programs N only from 10 to 255
// RULE10 - N resets to 25, multiplication 50
// RULE11 - Manual bit zero: calibration picks pump current
// RULE12 - Manual bit one: pump current from bits 5:3
// RULE13 - Bit 2 turns lock detection on
// RULE14 - Window field picks 128,256,512,1024 cycles
// RULE15 - Lock status readable at register 0 bit 24
// RULE16 - Disabled detection reads unlocked; error restarts window
`timescale 1ns/1ps
`include "pll_cfg_regs.svh"

module pll_refclk_config_control
  import pll_cfg_pkg::*;
#(
  parameter int WIN_W = 11                    // Lock window counter width
) (
  input  wire logic        clock,             // System clock, 200 MHz
  input  wire logic        rst_n,             // Synchronous reset, active low
  input  wire logic        reg_wr,            // Register write strobe
  input  wire logic        reg_rd,            // Register read strobe
  input  wire logic [7:0]  reg_addr,          // Register address
  input  wire logic [31:0] reg_wdata,         // Write data
  output logic [31:0]      reg_rdata,         // Read data, registered
  output logic             reg_rvalid,        // Read data valid pulse
  input  wire logic        ref_tick,          // One pulse per reference cycle
  input  wire logic        phase_in_range,    // Phase error within limits
  input  wire logic [2:0]  cal_cp_code,       // Pump code chosen by calibration
  output logic             div_reset_o,       // Input divider reset
  output logic             div_ref_tick,      // Divided reference enable
  output logic             doubler_on,        // Reference doubler active
  output logic             pll_enable,        // PLL on, drives system clock
  output logic             pll_ref_off,       // Reference disable, keep low
  output logic [7:0]       fb_div_n,          // Feedback divider N
  output logic [8:0]       pll_mult,          // Total multiplication 2N
  output logic [2:0]       charge_pump_current_code, // Pump current in use
  output logic             pll_locked         // Declared lock
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] cfg_ff;                        // pll_clock_config contents
  logic [31:0] nxt_cfg;
  logic [31:0] rdata_ff;                      // Read data
  logic [31:0] nxt_rdata;
  logic        rvalid_ff;                     // Read valid
  logic        nxt_rvalid;
  logic        lock_ff;                       // Declared lock, read at offset 0x00
  logic        nxt_lock;

  // Host write; open bits 31:23 and 7 are not stored
  always_comb begin
    nxt_cfg = cfg_ff;
    if (reg_wr && reg_addr == `PLL_CLK_CFG_OFFSET) begin
      nxt_cfg = reg_wdata & 32'h007f_ff7f;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata  = 32'h0000_0000;
    nxt_rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        `PRIMARY_CTRL_OFFSET: begin
          nxt_rdata[`LOCK_STATUS_BIT] = lock_ff;                    // RULE15
        end
        `PLL_CLK_CFG_OFFSET: begin
          nxt_rdata = cfg_ff;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Lock detector
  // ----------------------------------------------------------------
  lock_state_t      state_ff;                 // Detector state
  lock_state_t      nxt_state;
  logic [WIN_W-1:0] win_cnt_ff;               // Cycles held in range
  logic [WIN_W-1:0] nxt_win_cnt;
  logic [WIN_W-1:0] win_len;                  // lock_window_length in cycles
  logic             det_en;                   // Lock detection enable
  logic             dtick;                    // Divided reference tick

  assign det_en  = cfg_ff[`LOCK_DET_EN_BIT];
  assign win_len = WIN_W'(`LOCK_WIN_BASE << cfg_ff[`LOCK_WIN_HI:`LOCK_WIN_LO]); // RULE14

  // Counts divided reference ticks held in range; any excursion restarts
  always_comb begin
    nxt_state   = state_ff;
    nxt_win_cnt = win_cnt_ff;
    nxt_lock    = lock_ff;
    case (state_ff)
      LOCK_OFF: begin
        nxt_win_cnt = '0;
        nxt_lock    = 1'b0;                   // RULE16
        if (det_en) begin                     // RULE13
          nxt_state = LOCK_COUNT;
        end
      end
      LOCK_COUNT: begin
        if (!phase_in_range) begin
          nxt_win_cnt = '0;                   // RULE16
        end else if (dtick) begin
          if (win_cnt_ff == win_len - WIN_W'(1)) begin
            nxt_state = LOCK_HELD;
            nxt_lock  = 1'b1;                 // RULE14
          end else begin
            nxt_win_cnt = win_cnt_ff + WIN_W'(1);
          end
        end
      end
      LOCK_HELD: begin
        if (!phase_in_range) begin            // Excursion drops lock, recount
          nxt_state   = LOCK_COUNT;
          nxt_win_cnt = '0;
          nxt_lock    = 1'b0;                 // RULE16
        end
      end
      default: begin
        nxt_state = LOCK_OFF;
      end
    endcase
    if (!det_en) begin                        // Disable overrides every state
      nxt_state   = LOCK_OFF;
      nxt_win_cnt = '0;
      nxt_lock    = 1'b0;                     // RULE16
    end
  end

  // ----------------------------------------------------------------
  // Control outputs, all registered
  // ----------------------------------------------------------------
  logic       dbl_ff, nxt_dbl;                // Doubler active
  logic [2:0] cp_ff, nxt_cp;                  // Pump code in use
  logic [8:0] mult_ff, nxt_mult;              // 2N

  // Built from nxt_cfg so they change on the same edge as the word
  always_comb begin
    nxt_dbl  = nxt_cfg[`DBL_ENABLE_BIT] & nxt_cfg[`DBL_EDGE_BIT];           // RULE4
    nxt_cp   = nxt_cfg[`MANUAL_CP_BIT] ? nxt_cfg[`CP_CODE_HI:`CP_CODE_LO]  // RULE12
                                       : cal_cp_code;                       // RULE11
    nxt_mult = {nxt_cfg[`FB_DIV_HI:`FB_DIV_LO], 1'b0};                     // RULE8
  end

  // Divider for the reference enable
  pll_ref_divider #(
    .CNT_W (3)
  ) u_ref_div (
    .clock    (clock),
    .rst_n    (rst_n),
    .div_reset(cfg_ff[`DIV_RESET_BIT]),       // RULE1
    .div_sel  (cfg_ff[`IN_DIV_HI:`IN_DIV_LO]),
    .ref_tick (ref_tick),
    .div_tick (dtick)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset restores the default word with N at 25
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_ff     <= `PLL_CLK_CFG_RESET;       // RULE10
      rdata_ff   <= 32'h0000_0000;
      rvalid_ff  <= 1'b0;
      state_ff   <= LOCK_OFF;
      win_cnt_ff <= '0;
      lock_ff    <= 1'b0;
      dbl_ff     <= 1'b0;
      cp_ff      <= 3'h0;
      mult_ff    <= 9'h032;
    end else begin
      cfg_ff     <= nxt_cfg;
      rdata_ff   <= nxt_rdata;
      rvalid_ff  <= nxt_rvalid;
      state_ff   <= nxt_state;
      win_cnt_ff <= nxt_win_cnt;
      lock_ff    <= nxt_lock;
      dbl_ff     <= nxt_dbl;
      cp_ff      <= nxt_cp;
      mult_ff    <= nxt_mult;
    end
  end

  // Straight from flip-flops; the divided tick leaves the divider's flop
  assign reg_rdata                = rdata_ff;
  assign reg_rvalid               = rvalid_ff;
  assign div_reset_o              = cfg_ff[`DIV_RESET_BIT];     // RULE1
  assign div_ref_tick             = dtick;
  assign doubler_on               = dbl_ff;
  assign pll_enable               = cfg_ff[`PLL_ENABLE_BIT];    // RULE5
  assign pll_ref_off              = cfg_ff[`PLL_REF_DIS_BIT];
  assign fb_div_n                 = cfg_ff[`FB_DIV_HI:`FB_DIV_LO];
  assign pll_mult                 = mult_ff;
  assign charge_pump_current_code = cp_ff;
  assign pll_locked               = lock_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Detection off forces the status low on the next edge
  property p_unlock_when_off;
    @(posedge clock) disable iff (!rst_n)
      !det_en |=> !pll_locked;
  endproperty
  a_unlock_when_off: assert property (p_unlock_when_off) else $error("locked while off"); // RULE16

  property p_dbl_and;
    @(posedge clock) disable iff (!rst_n)
      doubler_on |-> cfg_ff[`DBL_ENABLE_BIT] && cfg_ff[`DBL_EDGE_BIT];
  endproperty
  a_dbl_and: assert property (p_dbl_and) else $error("doubler without both bits"); // RULE4

  property p_mult_2n;
    @(posedge clock) disable iff (!rst_n)
      pll_mult == {fb_div_n, 1'b0};
  endproperty
  a_mult_2n: assert property (p_mult_2n) else $error("multiplication not 2N"); // RULE8

  property p_manual_cp;
    @(posedge clock) disable iff (!rst_n)
      cfg_ff[`MANUAL_CP_BIT] |-> charge_pump_current_code == cfg_ff[`CP_CODE_HI:`CP_CODE_LO];
  endproperty
  a_manual_cp: assert property (p_manual_cp) else $error("manual pump code wrong"); // RULE12

  // Code is registered, so it trails calibration by one cycle; the reset edge is skipped
  property p_auto_cp;
    @(posedge clock) disable iff (!rst_n)
      !cfg_ff[`MANUAL_CP_BIT] && $past(rst_n)
        |-> charge_pump_current_code == $past(cal_cp_code);
  endproperty
  a_auto_cp: assert property (p_auto_cp) else $error("auto pump code wrong"); // RULE11

  property p_lock_needs_range;
    @(posedge clock) disable iff (!rst_n)
      $rose(pll_locked) |-> $past(phase_in_range) && $past(dtick) && $past(det_en);
  endproperty
  a_lock_needs_range: assert property (p_lock_needs_range) else $error("lock without window"); // RULE14

  property p_lock_read;
    @(posedge clock) disable iff (!rst_n)
      reg_rd && reg_addr == `PRIMARY_CTRL_OFFSET
        |=> reg_rvalid && reg_rdata[`LOCK_STATUS_BIT] == $past(lock_ff);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock readback wrong"); // RULE15

  property p_pll_en;
    @(posedge clock) disable iff (!rst_n)
      reg_wr && reg_addr == `PLL_CLK_CFG_OFFSET |=> pll_enable == $past(reg_wdata[`PLL_ENABLE_BIT]);
  endproperty
  a_pll_en: assert property (p_pll_en) else $error("pll enable not applied"); // RULE5

  // First edge out of reset shows the default N
  property p_reset_n;
    @(posedge clock) $rose(rst_n) |-> fb_div_n == `FB_DIV_RESET;
  endproperty
  a_reset_n: assert property (p_reset_n) else $error("N reset value wrong"); // RULE10

  property p_div_rst;
    @(posedge clock) disable iff (!rst_n)
      div_reset_o |=> !div_ref_tick;
  endproperty
  a_div_rst: assert property (p_div_rst) else $error("divided tick during reset"); // RULE1

  // Divider reset follows the written bit on the next edge
  property p_div_rst_wr;
    @(posedge clock) disable iff (!rst_n)
      reg_wr && reg_addr == `PLL_CLK_CFG_OFFSET
        |=> div_reset_o == $past(reg_wdata[`DIV_RESET_BIT]);
  endproperty
  a_div_rst_wr: assert property (p_div_rst_wr) else $error("divider reset not applied"); // RULE1

  // Any excursion while counting throws away the partial window
  property p_win_restart;
    @(posedge clock) disable iff (!rst_n)
      state_ff == LOCK_COUNT && !phase_in_range |=> win_cnt_ff == '0;
  endproperty
  a_win_restart: assert property (p_win_restart) else $error("window not restarted"); // RULE16

  // A locked loop that leaves range reports unlocked at once
  property p_lock_drop;
    @(posedge clock) disable iff (!rst_n)
      pll_locked && !phase_in_range |=> !pll_locked;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock held out of range"); // RULE16

endmodule : pll_refclk_config_control

// *** dv/ref_source_model.sv ***
// Reference source model: one-cycle reference ticks and phase-in-range level.
// Assumes the bench commands run, pacing and range through plain inputs.
`timescale 1ns/1ps

module ref_source_model (
  input  wire logic clock,          // System clock
  input  wire logic rst_n,          // Synchronous reset, active low
  input  wire logic run,            // Reference running
  input  wire logic slow,           // Tick every other cycle
  input  wire logic in_range,       // Commanded phase error state
  output logic      ref_tick,       // One pulse per reference cycle
  output logic      phase_in_range  // Phase error within limits
);
  logic phase_ff; // Pacing toggle for slow mode

  // ----------------------------------------------------------------
  // Tick pacing, changed just after the edge like a real source
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_ff       <= 1'b0;
      ref_tick       <= 1'b0;
      phase_in_range <= 1'b0;
    end else begin
      phase_ff       <= ~phase_ff;
      ref_tick       <= run && (!slow || phase_ff); // Stands one cycle in slow mode, high every cycle otherwise
      phase_in_range <= in_range;
    end
  end
endmodule : ref_source_model

// *** dv/tb_top.sv ***
// Bench for the PLL clock config word: table of writes, divider, lock window.
// Assumes the design keeps its assertions inside its own files.
`timescale 1ns/1ps

module tb_top;
  import pll_cfg_pkg::*;
  typedef struct { logic [31:0] word; logic [23:0] exp; } row_t;
  logic        clock, rst_n, reg_wr, reg_rd, run, slow, in_range, cnt_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic        reg_rvalid, ref_tick, phase_in_range, div_reset_o, div_ref_tick;
  logic        doubler_on, pll_enable, pll_ref_off, pll_locked;
  logic [2:0]  cal_cp_code, charge_pump_current_code;
  logic [7:0]  fb_div_n;
  logic [8:0]  pll_mult;
  int          err_total, checks_done, tick_cnt, seen;
  row_t        rows[5] = '{
    '{32'h0008_0a00, {4'b0000, 8'h0a, 9'h014, 3'h5}},  // Doubler half set, N at 10
    '{32'h0001_ff00, {4'b0000, 8'hff, 9'h1fe, 3'h5}},  // Edge half set, N at 255
    '{32'h000d_1958, {4'b0110, 8'h19, 9'h032, 3'h3}},  // Doubler, PLL on, manual pump
    '{32'h0040_1978, {4'b1000, 8'h19, 9'h032, 3'h7}},  // Divider reset held
    '{32'h0002_1900, {4'b0001, 8'h19, 9'h032, 3'h5}}}; // Ref-off bit, mirrored only

  pll_refclk_config_control pll_refclk_config_control_i (.clock(clock), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ref_tick(ref_tick),
    .phase_in_range(phase_in_range), .cal_cp_code(cal_cp_code),
    .div_reset_o(div_reset_o), .div_ref_tick(div_ref_tick), .doubler_on(doubler_on),
    .pll_enable(pll_enable), .pll_ref_off(pll_ref_off), .fb_div_n(fb_div_n),
    .pll_mult(pll_mult), .charge_pump_current_code(charge_pump_current_code),
    .pll_locked(pll_locked));
  ref_source_model ref_source_model_i (.clock(clock), .rst_n(rst_n), .run(run),
    .slow(slow), .in_range(in_range), .ref_tick(ref_tick),
    .phase_in_range(phase_in_range));

  // ----------------------------------------------------------------
  // Clock and in-range divided tick counter, cleared when range drops
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (!cnt_en || !phase_in_range) tick_cnt <= 0;
    else if (div_ref_tick && !pll_locked) tick_cnt <= tick_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Host port tasks and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1, "read answer pulse");
    d = reg_rdata;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic count_ticks(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (div_ref_tick === 1'b1) c++;
    end
  endtask : count_ticks
  task automatic wait_lock(input int limit);
    repeat (limit) begin
      @(posedge clock);
      #1;
      if (pll_locked === 1'b1) return;
    end
    err_total++;
    $display("CHECK FAILED at %0t: lock wait expired", $time);
  endtask : wait_lock
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog, well past the longest lock window run
  initial begin
    #100us;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    run = 1'b1; slow = 1'b0; in_range = 1'b0; cnt_en = 1'b0; cal_cp_code = 3'h5;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk({11'h0, div_reset_o, doubler_on, pll_enable, pll_ref_off, fb_div_n, pll_mult},
        {11'h0, 4'b0000, 8'h19, 9'h032}, "reset outputs");
    rd(8'h02, rd_val);
    chk(rd_val, 32'h0000_1900, "reset word");
    $display("Test reset done");
    foreach (rows[i]) begin
      wr(8'h02, rows[i].word);
      chk({8'h0, div_reset_o, doubler_on, pll_enable, pll_ref_off, fb_div_n, pll_mult,
           charge_pump_current_code}, {8'h0, rows[i].exp}, "table row");
    end
    wr(8'h00, 32'h0100_0000);
    $display("Test table done");
    // Open bits, unmapped write and read
    wr(8'h02, 32'hffff_ffff);
    wr(8'h05, 32'h0000_0000);
    rd(8'h02, rd_val);
    chk(rd_val, 32'h007f_ff7f, "open bits and stray write");
    rd(8'h05, rd_val);
    chk(rd_val, 32'h0, "unmapped read");
    // Automatic pump code follows calibration
    wr(8'h02, 32'h0000_1900);
    cal_cp_code <= 3'h2;
    repeat (3) @(posedge clock);
    #1;
    chk({29'h0, charge_pump_current_code}, 32'h2, "calibrated pump code");
    $display("Test access done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h02, 32'h0000_1900 | (s << 20));
      repeat (10) @(posedge clock);
      count_ticks(64, seen);
      chk(seen, 64 >> s, "divided tick count");
    end
    wr(8'h02, 32'h0040_1900);
    repeat (4) @(posedge clock);
    count_ticks(64, seen);
    chk(seen, 0, "divider held in reset");
    slow <= 1'b1;
    wr(8'h02, 32'h0010_1900);
    repeat (10) @(posedge clock);
    count_ticks(64, seen);
    chk(seen, 16, "slow reference, divide by two");
    slow <= 1'b0;
    $display("Test divider done");
    for (int f = 0; f < 4; f++) begin
      in_range <= 1'b0;
      wr(8'h02, 32'h0010_1904 | f);
      cnt_en = 1'b1;
      in_range <= 1'b1;
      wait_lock(3000);
      chk(tick_cnt, 128 << f, "lock window length");
      rd(8'h00, rd_val);
      chk(rd_val & 32'h0100_0000, 32'h0100_0000, "lock status bit");
      cnt_en = 1'b0;
    end
    // Range lost once mid-window, and once after lock
    in_range <= 1'b0;
    wr(8'h02, 32'h0010_1904);
    cnt_en = 1'b1;
    in_range <= 1'b1;
    repeat (120) @(posedge clock);
    in_range <= 1'b0;
    @(posedge clock);
    in_range <= 1'b1;
    wait_lock(3000);
    chk(tick_cnt, 128, "window restarted");
    in_range <= 1'b0;
    @(posedge clock);
    in_range <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk({31'h0, pll_locked}, 32'h0, "lock lost on range drop");
    wr(8'h02, 32'h0010_1900);
    repeat (400) @(posedge clock);
    #1;
    chk({31'h0, pll_locked}, 32'h0, "detection off");
    rd(8'h00, rd_val);
    chk(rd_val, 32'h0, "status reads unlocked");
    $display("Test lock done");
    print_verdict();
  end
endmodule : tb_top
